// ---- bench/sar_adc_conversion_control_tb.sv ----
module sar_adc_conversion_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, sys_rst = 1, conversion_start_n = 0, ready_clear_n = 1, stall = 0;
  logic internal_clock_mode = 0, comparator_in = 0, result_taken;
  logic upper_byte_output_enable_n = 0, lower_bits_output_enable_n = 0;
  logic [9:0] result_out, result_oe_n, cap_switch, stream_data, held, code = 10'h000;
  logic result_ready_flag, track_enable, clock_run, stream_valid;
  logic [3:0] period;
  logic [9:0] tab [5] = '{10'h000, 10'h3ff, 10'h200, 10'h155, 10'h2aa};
  int n_errors = 0, n_tests = 0, k;
  always #4 core_clk = ~core_clk;
  sarcc_ctrl i_sarcc_ctrl (.*);
  sarcc_host i_sarcc_host (.*);
  // ideal comparator: trial word not above the input keeps the bit
  always @(negedge core_clk) comparator_in <= (cap_switch <= code);
  task automatic chk(string s, logic [9:0] seen, logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait for ready rising, counted in cycles
  task automatic rise(output int c);
    c = 0;
    while (result_ready_flag !== 1'b0 && c < 300) begin c++; cyc(1); end
    while (result_ready_flag !== 1'b1 && c < 300) begin c++; cyc(1); end
    if (c >= 300) begin
      n_errors++;
      print_verdict();
    end
  endtask
  initial begin
    cyc(3);
    sys_rst = 0;
    // free run over a table of input codes
    foreach (tab[i]) begin
      code = tab[i];
      rise(k);
      rise(k);
      chk("cycle", 10'(k), 10'h00d);
      chk("result", result_out, code);
      cyc(3);
      chk("latched", held, code);
    end
    $display("test 1 done");
    for (int i = 0; i < 4; i++) begin
      {upper_byte_output_enable_n, lower_bits_output_enable_n} = 2'(i);
      cyc(6);
      chk("enables", result_oe_n, {{8{i[1]}}, {2{i[0]}}});
    end
    stall = 1;
    cyc(45);
    chk("stream", {stream_valid, stream_data}, {1'b1, code});
    stall = 0;
    $display("test 2 done");
    // internal clock stops in period 2 with ready held
    internal_clock_mode = 1;
    conversion_start_n = 1;
    cyc(40);
    chk("stopped", {3'h0, clock_run, track_enable, result_ready_flag, period}, 10'h032);
    conversion_start_n = 0;
    cyc(4);
    chk("restart", {8'h00, clock_run, result_ready_flag}, 10'h002);
    conversion_start_n = 1;
    rise(k);
    chk("result", result_out, code);
    cyc(5);
    ready_clear_n = 0;
    cyc(4);
    chk("clear", {9'h000, result_ready_flag}, 10'h000);
    ready_clear_n = 1;
    $display("test 3 done");
    // external clock holds period 2 until start
    internal_clock_mode = 0;
    cyc(20);
    chk("hold", {6'h00, period}, 10'h002);
    conversion_start_n = 0;
    k = 0;
    while (period !== 4'h3 && k < 10) begin k++; cyc(1); end
    chk("advance", {5'h00, result_ready_flag, period}, 10'h003);
    $display("test 4 done");
    print_verdict();
  end
endmodule // sar_adc_conversion_control_tb

// ---- bench/sarcc_ctrl_asserts.sv ----
module sarcc_ctrl_chk (
  input wire logic       core_clk,                   // clock
  input wire logic       sys_rst,                    // reset
  input wire logic       ready_clear_n,              // clear pin
  input wire logic       upper_byte_output_enable_n, // upper enable
  input wire logic       lower_bits_output_enable_n, // lower enable
  input wire logic [9:0] result_oe_n,                // bit enables
  input wire logic       result_ready_flag,          // ready
  input wire logic       track_enable,               // tracking
  input wire logic [9:0] cap_switch,                 // switches
  input wire logic       clock_run,                  // clock on
  input wire logic [3:0] period                      // period
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // enables pass a two-flop sync and a register, five cycles covers it
  AST_UP_ON: assert property ((!upper_byte_output_enable_n)[*5] |-> result_oe_n[9:2] == 8'h00)
    else $error("upper bits not enabled");
  AST_UP_OFF: assert property (upper_byte_output_enable_n[*5] |-> result_oe_n[9:2] == 8'hff)
    else $error("upper bits not released");
  AST_LO_ON: assert property ((!lower_bits_output_enable_n)[*5] |-> result_oe_n[1:0] == 2'b00)
    else $error("lower bits not enabled");
  AST_LO_OFF: assert property (lower_bits_output_enable_n[*5] |-> result_oe_n[1:0] == 2'b11)
    else $error("lower bits not released");
  // only period 2 may hold, only period 13 wraps
  AST_STEP: assert property (period != 4'h2 && period != 4'hd |=> period == $past(period) + 4'h1)
    else $error("period did not advance");
  AST_WRAP: assert property (period == 4'hd |=> period == 4'h1)
    else $error("cycle did not wrap");
  AST_STOP: assert property ((!clock_run)[*2] |-> period == 4'h2)
    else $error("clock stopped outside period 2");
  AST_TRACK: assert property (period == 4'h2 |-> track_enable)
    else $error("not tracking in period 2");
  AST_CAP: assert property (track_enable[*2] |-> cap_switch == 10'h000)
    else $error("switches set while tracking");
  AST_CLEAR: assert property ((!ready_clear_n)[*5] |-> !result_ready_flag)
    else $error("ready not cleared");
  AST_RISE: assert property ($rose(result_ready_flag) |-> period inside {4'hd, 4'h1})
    else $error("ready rose mid conversion");
endmodule // sarcc_ctrl_chk

bind sarcc_ctrl sarcc_ctrl_chk i_sarcc_ctrl_chk (.*);

// ---- bench/sarcc_host.sv ----
module sarcc_host (
  input  wire logic       core_clk,          // clock
  input  wire logic       result_ready_flag, // ready
  input  wire logic [9:0] result_out,        // result
  input  wire logic       stall,             // hold off taking
  output logic            result_taken,      // take word
  output logic      [9:0] held               // latched result
);
  timeunit 1ns;
  timeprecision 1ps;
  // trailing edge: the leading edge has no setup guarantee
  always @(negedge result_ready_flag) held <= result_out;
  // stall holds the buffer full; results arriving while it is full are lost
  always @(negedge core_clk) result_taken <= ~stall;
  initial result_taken = 1'b0;
endmodule // sarcc_host

// ---- rtl/sarcc_buf.sv ----
// two-entry buffer; a word offered while both entries are full is not taken
module sarcc_buf #(
  parameter int unsigned W = 10
) (
  input  wire logic         core_clk,  // clock
  input  wire logic         sys_rst,   // async reset
  input  wire logic [W-1:0] in_data,   // word in
  input  wire logic         in_valid,  // word offered
  output logic              in_ready,  // room available
  output logic      [W-1:0] out_data,  // head word
  output logic              out_valid, // head valid
  input  wire logic         out_ready  // receiver takes
);
  logic [W-1:0] mem [sarcc_pkg::BUF_DEPTH];
  logic         wp, rp;
  logic [1:0]   cnt;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;
  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rp];
  // pointers and fill count
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      wp  <= wp ^ push;
      rp  <= rp ^ pop;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
  // storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule // sarcc_buf

// ---- rtl/sarcc_ctrl.sv ----
// Overview of operation
// - start held low: back-to-back 13-period cycles
// - track periods 1 to 3, then disconnect
// - outputs update early in next period 1
// - ready rises period 1, falls period 2
// - ready clear input drops flag synchronously, after a two-flop sync
// - upper enable low drives bits 2-9
// - lower enable low drives bits 0-1
// - no start: internal clock stops in period 2
// - while stopped: track, ready stays high
// - start pulse clears ready, restarts conversion
// - stopped period 2 stretched, others normal
// - external clock: hold in period 2
// - start clears ready, next edge period 3
// - ready falls at later of period 2/start
// - held clear drops ready after delay
// - straight binary code, zero at low end
// - start recognised only after period 13
// - all sequencing on rising clock edge
// - test bit 9 period 4, 8..1 periods 5-12
// - period 13: bit 0, transfer, track, ready
module sarcc_ctrl (
  input  wire logic        core_clk,                   // converter clock
  input  wire logic        sys_rst,                    // async reset, high
  input  wire logic        conversion_start_n,         // start, low active, pin
  input  wire logic        ready_clear_n,              // ready clear, low active, pin
  input  wire logic        internal_clock_mode,        // 1: internal clock gated when idle
  input  wire logic        comparator_in,              // comparator decision
  input  wire logic        upper_byte_output_enable_n, // bits 9..2 enable, pin
  input  wire logic        lower_bits_output_enable_n, // bits 1..0 enable, pin
  input  wire logic        result_taken,               // receiver takes stream word
  output logic      [9:0]  result_out,                 // result bits driven value
  output logic      [9:0]  result_oe_n,                // per-bit enable, low drives
  output logic             result_ready_flag,          // data ready
  output logic             track_enable,               // input connected for tracking
  output logic      [9:0]  cap_switch,                 // capacitor to upper reference
  output logic             clock_run,                  // internal clock running
  output logic      [9:0]  stream_data,                // buffered result word
  output logic             stream_valid,               // buffered word valid
  output logic      [3:0]  period                      // current clock period
);
  logic       start_n_s, clear_n_s, up_n_s, lo_n_s;
  logic [3:0] per;
  logic [9:0] sar;
  logic [9:0] out_reg;
  logic       rdy;
  logic       start_seen;
  sarcc_pkg::sarcc_state_t state;
  logic [9:0] buf_q;
  logic       buf_v, buf_in_ready;

  // all pin inputs pass two flops first
  sarcc_sync #(.RST_VAL(1'b1)) u_sync_start (
    .core_clk (core_clk), .sys_rst (sys_rst), .d (conversion_start_n), .q (start_n_s));
  sarcc_sync #(.RST_VAL(1'b1)) u_sync_clear (
    .core_clk (core_clk), .sys_rst (sys_rst), .d (ready_clear_n), .q (clear_n_s));
  sarcc_sync #(.RST_VAL(1'b1)) u_sync_up (
    .core_clk (core_clk), .sys_rst (sys_rst), .d (upper_byte_output_enable_n),
    .q (up_n_s));
  sarcc_sync #(.RST_VAL(1'b1)) u_sync_lo (
    .core_clk (core_clk), .sys_rst (sys_rst), .d (lower_bits_output_enable_n),
    .q (lo_n_s));

  // period decode, used for sequencing
  wire in_p1     = (per == 4'h1);
  wire in_p2     = (per == 4'h2);
  wire in_last   = (per == 4'(sarcc_pkg::LAST_PERIOD));
  wire in_track  = (per <= 4'(sarcc_pkg::TRACK_LAST));
  wire in_test   = (per >= 4'(sarcc_pkg::FIRST_TEST));
  wire start_now = !start_n_s;
  // start latched during period 1 only after period 13 ended
  wire go_on     = start_now || start_seen;
  // a period-2 wait holds until a start shows at an edge
  wire hold_p2   = in_p2 && !go_on;
  wire [3:0] bit_idx = 4'(sarcc_pkg::LAST_PERIOD) - per;                // 9..0
  wire [9:0] trial   = 10'h001 << bit_idx;
  wire [9:0] keep    = comparator_in ? sar : (sar & ~trial);
  // keep the decided bit, raise the next trial bit; period 12 marks bit 0
  wire [9:0] next_mark = keep | (trial >> 1);
  wire [9:0] final_code = comparator_in ? sar : (sar & ~10'h001);
  // next-cycle view so the switches show the trial that is being tested
  wire [3:0] next_per  = in_last ? 4'h1 : (hold_p2 ? per : per + 4'h1);
  wire       next_track = (next_per <= 4'(sarcc_pkg::TRACK_LAST));
  wire [9:0] next_sar  = in_last ? 10'h200 : (in_test ? next_mark : sar);

  // period counter, rising edge only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per   <= sarcc_pkg::PERIOD_RST;
      state <= sarcc_pkg::SARCC_WAIT;
    end else if (in_last) begin
      per   <= 4'h1;
      state <= sarcc_pkg::SARCC_RUN;
    end else if (hold_p2) begin
      per   <= per;
      state <= sarcc_pkg::SARCC_WAIT;
    end else begin
      per   <= per + 4'h1;
      state <= sarcc_pkg::SARCC_RUN;
    end
  end

  // start seen in period 1 carries the free run through period 2
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_seen <= 1'b0;
    end else if (in_p1) begin
      start_seen <= start_now;
    end else begin
      start_seen <= 1'b0;
    end
  end

  // successive approximation register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sar <= 10'h200;
    end else if (in_last) begin
      sar <= 10'h200;
    end else if (in_test) begin
      sar <= next_mark;
    end
  end

  // output register loads at end of period 13
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg <= sarcc_pkg::RESULT_RST;
    end else if (in_last) begin
      out_reg <= final_code;
    end
  end

  // ready flag; the clear pin wins over set since the pin is a level
  wire ready_set = in_last;
  wire ready_drop = !clear_n_s
                 || (in_p2 && go_on)
                 || (state == sarcc_pkg::SARCC_WAIT && start_now);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy <= 1'b0;
    end else if (ready_set && clear_n_s) begin
      rdy <= 1'b1;
    end else if (ready_drop) begin
      rdy <= 1'b0;
    end
  end

  // stream buffer copies each result; during receiver stall, results offered while full are dropped
  sarcc_buf #(.W(sarcc_pkg::RES_W)) u_buf (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_data   (final_code),
    .in_valid  (in_last),
    .in_ready  (buf_in_ready),
    .out_data  (buf_q),
    .out_valid (buf_v),
    .out_ready (result_taken)
  );

  // enable decode: each pair independent
  wire [9:0] next_oe_n = {{8{up_n_s}}, {2{lo_n_s}}};
  wire       next_clock_run = !(internal_clock_mode && hold_p2);

  // registered outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_out        <= sarcc_pkg::RESULT_RST;
      result_oe_n       <= 10'h3ff;
      result_ready_flag <= 1'b0;
      track_enable      <= 1'b1;
      cap_switch        <= 10'h000;
      clock_run         <= 1'b0;
      stream_data       <= sarcc_pkg::RESULT_RST;
      stream_valid      <= 1'b0;
      period            <= sarcc_pkg::PERIOD_RST;
    end else begin
      result_out        <= out_reg;
      result_oe_n       <= next_oe_n;
      result_ready_flag <= rdy && clear_n_s;
      track_enable      <= next_track;
      cap_switch        <= next_track ? 10'h000 : next_sar;
      clock_run         <= next_clock_run;
      stream_data       <= buf_q;
      stream_valid      <= buf_v && !result_taken;
      period            <= per;
    end
  end
endmodule // sarcc_ctrl

// ---- rtl/sarcc_pkg.sv ----
package sarcc_pkg;
  localparam int unsigned RES_W        = 10;
  localparam int unsigned LAST_PERIOD  = 13;
  localparam int unsigned TRACK_LAST   = 3;
  localparam int unsigned FIRST_TEST   = 4;
  localparam logic [3:0]  PERIOD_RST   = 4'h2;
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned UPPER_LSB    = 2;
  localparam int unsigned BUF_DEPTH    = 2;
  typedef enum logic [1:0] {SARCC_RUN, SARCC_WAIT} sarcc_state_t;
endpackage

// ---- rtl/sarcc_sync.sv ----
// two flip-flop synchroniser, reset value given
module sarcc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic core_clk,  // clock
  input  wire logic sys_rst,   // async reset
  input  wire logic d,         // asynchronous level
  output logic      q          // synchronised level
);
  logic meta;
  // meta is read by q only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sarcc_sync
